/* File: bench/tb_top.sv */
// tb_top: register-level testbench of the result, gain and count block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import arc_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic clk_i, resetn_i, wr_i, rd_i, first_meas_i;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic [3:0] done_v;
  logic [1:0] start_v, power_state_i, input_front_stage_gain_o, first_amp_gain_o;
  logic [23:0] res_v;
  logic cur_ready_o, volt_ready_o, temp_ready_o, second_amp_gain_o;
  logic [2:0] interrupt_status_o;
  logic [7:0] gw;
  int fail_count, total_checks;

  arc_regs arc_regs_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .cur_done_i(done_v[0]), .current_result_i(res_v),
    .volt_done_i(done_v[1]), .voltage_result_i(res_v),
    .temp_done_i(done_v[2]), .temperature_result_i(res_v[15:0]),
    .ref_done_i(done_v[3]), .reference_resistor_result_i(res_v[15:0]),
    .current_conversion_start_i(start_v[0]), .voltage_conversion_start_i(start_v[1]),
    .power_state_i(power_state_i), .first_meas_i(first_meas_i),
    .cur_ready_o(cur_ready_o), .volt_ready_o(volt_ready_o), .temp_ready_o(temp_ready_o),
    .input_front_stage_gain_o(input_front_stage_gain_o),
    .first_amp_gain_o(first_amp_gain_o), .second_amp_gain_o(second_amp_gain_o),
    .interrupt_status_o(interrupt_status_o)
  );

  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  // 20 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // cuts a hang short, the tests need well under 2000 cycles
  initial
  begin
    #(20000 * 50);
    fail_count++;
    $display("watchdog ran out at %0t", $time);
    wrap_up;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // compares one value and counts the outcome
  task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    wdata_i <= ~d;
  endtask

  // one-cycle read strobe, data taken in the cycle after it
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // reads n bytes little endian and compares them
  task automatic chk(input logic [7:0] a, input int n, input logic [23:0] exp);
    logic [23:0] v;
    logic [7:0] d;
    v = 24'h000000;
    for (int i = 0; i < n; i++)
    begin
      reg_rd(a + 8'(i), d);
      v[8*i +: 8] = d;
    end
    check(v, exp, $sformatf("register %h", a));
  endtask

  // one result of channel ch (0 cur, 1 volt, 2 temp, 3 ref), then the strobes
  task automatic result(input int ch, input logic [23:0] v, input logic [2:0] exp_rdy);
    @(posedge clk_i);
    done_v <= 4'h1 << ch;
    res_v <= v;
    @(posedge clk_i);
    done_v <= 4'h0;
    res_v <= ~v;
    #1;
    check({cur_ready_o, volt_ready_o, temp_ready_o}, exp_rdy, "ready strobes");
  endtask

  // rising edge of the start bit of channel ch
  task automatic start_edge(input int ch);
    @(posedge clk_i);
    start_v <= 2'b00;
    @(posedge clk_i);
    start_v <= 2'b01 << ch;
    @(posedge clk_i);
  endtask

  // prints the counts and the verdict, then ends the run
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    {wr_i, rd_i, first_meas_i, addr_i, wdata_i, done_v, start_v, res_v} = '0;
    power_state_i = 2'b00;
    resetn_i = 1'b0;
    fail_count = 0;
    total_checks = 0;
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    // reset values of every register
    chk(CUR_RESULT_OFS, 3, 24'h000000);
    chk(VOLT_RESULT_OFS, 3, 24'h000000);
    chk(REF_RESULT_OFS, 2, 24'h000000);
    chk(TEMP_RESULT_OFS, 2, 24'h000000);
    chk(CUR_COUNTER_OFS, 2, 24'h000000);
    chk(VOLT_COUNTER_OFS, 1, 24'h000000);
    chk(CUR_LIMIT_OFS, 2, 24'h000000);
    chk(VOLT_LIMIT_OFS, 1, 24'h000000);
    chk(GAIN_OFS, 1, 24'h000000);
    chk(STATUS_OFS, 1, 24'h000000);
    $display("test reset values done");
    // every gain code of every field
    for (int c = 0; c < 4; c++)
    begin
      gw = {3'b000, 1'(c), 2'(3 - c), 2'(c)};
      reg_wr(GAIN_OFS, gw);
      #1;
      check({second_amp_gain_o, first_amp_gain_o, input_front_stage_gain_o}, gw, "gain");
      chk(GAIN_OFS, 1, gw);
    end
    reg_wr(GAIN_OFS, 8'h15);
    chk(GAIN_OFS, 1, 24'h000015);
    // write and read with no idle cycle between the strobes
    @(posedge clk_i);
    addr_i <= GAIN_OFS;
    wdata_i <= 8'h0a;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o, 24'h00000a, "gain back to back");
    $display("test gain done");
    // results land in their registers, temperature negated
    result(0, 24'h812345, 3'b100);
    chk(CUR_RESULT_OFS, 3, 24'h812345);
    result(1, 24'h7f00a5, 3'b010);
    chk(VOLT_RESULT_OFS, 3, 24'h7f00a5);
    result(2, 24'h000005, 3'b001);
    chk(TEMP_RESULT_OFS, 2, 24'h00fffb);
    result(3, 24'h00c3d2, 3'b000);
    chk(REF_RESULT_OFS, 2, 24'h00c3d2);
    reg_wr(CUR_RESULT_OFS, 8'h55);
    chk(CUR_RESULT_OFS, 3, 24'h812345);
    chk(8'h70, 1, 24'h000000);
    check(interrupt_status_o, 3'b111, "status");
    chk(STATUS_OFS, 1, 24'h0000e0);
    reg_wr(STATUS_OFS, 8'he0);
    chk(STATUS_OFS, 1, 24'h000000);
    $display("test results done");
    // current channel: limit 0, limit 1, limit 3 with wrap
    chk(CUR_COUNTER_OFS, 2, 24'h000000);
    reg_wr(CUR_LIMIT_OFS, 8'h01);
    result(0, 24'h000001, 3'b100);
    result(0, 24'h000002, 3'b100);
    reg_wr(CUR_LIMIT_OFS + 8'h01, 8'h01);
    reg_wr(CUR_LIMIT_OFS, 8'h03);
    chk(CUR_LIMIT_OFS, 2, 24'h000103);
    reg_wr(CUR_LIMIT_OFS + 8'h01, 8'h00);
    start_edge(0);
    chk(CUR_COUNTER_OFS, 2, 24'h000000);
    for (int i = 1; i <= 4; i++)
    begin
      result(0, 24'(i), (i == 3) ? 3'b100 : 3'b000);
      chk(CUR_COUNTER_OFS, 2, (i == 4) ? 24'h000001 : 24'(i));
    end
    start_edge(0);
    chk(CUR_COUNTER_OFS, 2, 24'h000000);
    $display("test current counting done");
    // voltage channel: limit width, limit 2 with wrap, limit 0
    reg_wr(VOLT_LIMIT_OFS, 8'h0f);
    chk(VOLT_LIMIT_OFS, 1, 24'h00000f);
    reg_wr(VOLT_LIMIT_OFS, 8'h02);
    start_edge(1);
    chk(VOLT_COUNTER_OFS, 1, 24'h000000);
    for (int i = 1; i <= 3; i++)
    begin
      result(1, 24'(i), (i == 2) ? 3'b010 : 3'b000);
      chk(VOLT_COUNTER_OFS, 1, (i == 3) ? 24'h000001 : 24'(i));
    end
    result(0, 24'h000007, 3'b000);
    // low power: first measurement clears both counters
    @(posedge clk_i);
    power_state_i <= 2'b01;
    first_meas_i <= 1'b1;
    @(posedge clk_i);
    first_meas_i <= 1'b0;
    chk(VOLT_COUNTER_OFS, 1, 24'h000000);
    chk(CUR_COUNTER_OFS, 2, 24'h000000);
    reg_wr(VOLT_LIMIT_OFS, 8'h00);
    result(1, 24'h000009, 3'b010);
    result(1, 24'h00000a, 3'b010);
    $display("test voltage counting done");
    // ultra-low power: a start edge keeps the count, the first measurement clears it
    @(posedge clk_i);
    power_state_i <= 2'b10;
    result(0, 24'h00000b, 3'b000);
    start_edge(0);
    chk(CUR_COUNTER_OFS, 2, 24'h000001);
    @(posedge clk_i);
    first_meas_i <= 1'b1;
    @(posedge clk_i);
    first_meas_i <= 1'b0;
    chk(CUR_COUNTER_OFS, 2, 24'h000000);
    $display("test ultra-low power done");
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire

/* File: core/arc_cnt_if.sv */
// arc_cnt_if: link between the register block and one result counter
`timescale 1ns/1ns
`default_nettype none
interface arc_cnt_if #(parameter int W = 16);
  logic clear;
  logic done;
  logic [W-1:0] limit;
  logic [W-1:0] count;
  logic strobe;
  modport ctl (output clear, output done, output limit, input count, input strobe);
  modport cnt (input clear, input done, input limit, output count, output strobe);
endinterface
`default_nettype wire

/* File: core/arc_pkg.sv */
// arc_pkg: register map, field layout and reset values of the result/count block
//
// Notes on behaviour
// RULE_01: latest voltage result, 24-bit signed, read-only at 05..07, zero after reset.
// RULE_02: 16-bit read-only temperature result at 0A..0B, stored sign-inverted.
// RULE_03: 16-bit read-only reference-resistor result at 08..09.
// RULE_04: gain bits 1:0 pick front-stage gain 1/2/4/8, reset 0.
// RULE_05: gain bits 3:2 pick first amplifier gain 1/2/4/8, reset 0.
// RULE_06: gain bit 4 picks second amplifier gain 4 or 8, reset 0.
// RULE_07: gain bits 7:5 read zero; software writes zeros there.
// RULE_08: status bits 7..5 flag finished current, voltage, temperature conversions.
// RULE_09: temperature ready strobe after every temperature result, no counting.
// RULE_10: current and voltage strobes per result or per programmed result count.
// RULE_11: current count limit 16-bit read-write; zero means strobe every result.
// RULE_12: current result counter readable any time, 16-bit, resets to zero.
// RULE_13: current counter clears on start rising edge in full power, first low-power measurement.
// RULE_14: current counter goes to 1 at the result after the limit was reached.
// RULE_15: voltage count limit up to 15; zero means strobe every result.
// RULE_16: voltage counter clears on start rising edge in full power, first low-power measurement.
// RULE_17: voltage counter goes to 1 at the result after the limit was reached.
// RULE_18: voltage result counter readable by software at any time.
// RULE_19: a limit of 1 acts like single counting, strobe every result.
// RULE_20: voltage limit bits 3:0 at 45, voltage counter bits 3:0 at 1E.
// RULE_21: latest current result, 24-bit signed, read-only at 02..04, zero after reset.
// RULE_22: counter steps per result; strobe in the cycle it equals the limit.
package arc_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CUR_RESULT_OFS = 8'h02;
  localparam logic [7:0] VOLT_RESULT_OFS = 8'h05;
  localparam logic [7:0] REF_RESULT_OFS = 8'h08;
  localparam logic [7:0] TEMP_RESULT_OFS = 8'h0a;
  localparam logic [7:0] CUR_COUNTER_OFS = 8'h1b;
  localparam logic [7:0] VOLT_COUNTER_OFS = 8'h1e;
  localparam logic [7:0] CUR_LIMIT_OFS = 8'h40;
  localparam logic [7:0] VOLT_LIMIT_OFS = 8'h45;
  localparam logic [7:0] GAIN_OFS = 8'h52;
  localparam logic [7:0] STATUS_OFS = 8'h60;
  // ----------------------------------------------------------------
  // field layout and widths
  // ----------------------------------------------------------------
  localparam int CUR_CNT_W = 16;
  localparam int VOLT_CNT_W = 4;
  localparam int GAIN_W = 5;
  localparam int FRONT_LSB = 0;
  localparam int FIRST_LSB = 2;
  localparam int SECOND_BIT = 4;
  localparam int STATUS_LSB = 5;
  localparam int ST_CUR = 2;
  localparam int ST_VOLT = 1;
  localparam int ST_TEMP = 0;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [23:0] RESULT24_RST = 24'h000000;
  localparam logic [15:0] RESULT16_RST = 16'h0000;
  localparam logic [15:0] CUR_LIMIT_RST = 16'h0000;
  localparam logic [3:0] VOLT_LIMIT_RST = 4'h0;
  localparam logic [4:0] GAIN_RST = 5'h00;
  // ----------------------------------------------------------------
  // power states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    full_power_state,
    low_power_state,
    ultra_low_power_state
  } arc_power_t;
endpackage

/* File: core/arc_rcount.sv */
// arc_rcount: result counter and conversion-ready strobe of one channel
`timescale 1ns/1ns
`default_nettype none
module arc_rcount #(parameter int W = 16)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  arc_cnt_if.cnt port
);
  import arc_pkg::*;

  typedef struct packed {
    logic [W-1:0] count;
    logic strobe;
  } arc_rc_t;

  arc_rc_t st;
  arc_rc_t next_st;
  logic [W-1:0] base;
  logic reached;

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  // clear first, so a result in the clearing cycle is counted as the first
  always_comb
  begin
    next_st = st;
    next_st.strobe = 1'b0;
    base = port.clear ? '0 : st.count; // RULE_13 RULE_16
    reached = (port.limit != '0) && (base >= port.limit);
    next_st.count = base;
    if (port.done)
    begin
      if (port.limit == '0)
      begin
        next_st.strobe = 1'b1; // RULE_10
      end
      else
      begin
        next_st.count = reached ? W'(1) : W'(base + W'(1)); // RULE_14 RULE_17 RULE_22
        next_st.strobe = (next_st.count == port.limit); // RULE_19 RULE_22
      end
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign port.count = st.count;
  assign port.strobe = st.strobe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_free_result;
    port.done && !port.clear;
  endsequence

  a_single_strobe: assert property (port.done && port.limit == '0 |=> port.strobe) // RULE_10
    else $error("no strobe for a result in single counting");
  a_wrap_one: assert property (s_free_result ##0 (port.limit != '0 && port.count >= port.limit)
      |=> port.count == W'(1)) // RULE_14
    else $error("counter did not restart at one");
  a_limit_strobe: assert property (port.strobe |-> port.limit == '0 || port.count == port.limit) // RULE_22
    else $error("strobe without reaching the limit");
  a_step_up: assert property (s_free_result ##0 (port.limit != '0 && port.count < port.limit)
      |=> port.count == W'($past(port.count) + W'(1))) // RULE_22
    else $error("counter did not step by one");
endmodule // arc_rcount
`default_nettype wire

/* File: core/arc_regs.sv */
// arc_regs: result registers, current-path gain and conversion-ready logic
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module arc_regs
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic cur_done_i,
  input wire logic [23:0] current_result_i,
  input wire logic volt_done_i,
  input wire logic [23:0] voltage_result_i,
  input wire logic temp_done_i,
  input wire logic [15:0] temperature_result_i,
  input wire logic ref_done_i,
  input wire logic [15:0] reference_resistor_result_i,
  input wire logic current_conversion_start_i,
  input wire logic voltage_conversion_start_i,
  input wire logic [1:0] power_state_i,
  input wire logic first_meas_i,
  output logic cur_ready_o,
  output logic volt_ready_o,
  output logic temp_ready_o,
  output logic [1:0] input_front_stage_gain_o,
  output logic [1:0] first_amp_gain_o,
  output logic second_amp_gain_o,
  output logic [2:0] interrupt_status_o
);
  import arc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [23:0] current_result;
    logic [23:0] voltage_result;
    logic [15:0] reference_resistor_result;
    logic [15:0] temperature_result;
    logic [15:0] current_result_count_limit;
    logic [3:0] voltage_result_count_limit;
    logic [4:0] current_path_gain;
    logic [2:0] interrupt_status;
    logic [7:0] rdata;
    logic cur_start_prev;
    logic volt_start_prev;
    logic temp_ready;
  } arc_regs_t;

  arc_regs_t st;
  arc_regs_t next_st;
  logic low_power;
  logic cur_clear;
  logic volt_clear;
  logic [2:0] status_set;

  arc_cnt_if #(.W(CUR_CNT_W)) cur_if ();
  arc_cnt_if #(.W(VOLT_CNT_W)) volt_if ();

  // byte of a multi-byte register seen at an address, zero if outside
  function automatic logic [7:0] byte_at(input logic [7:0] addr, input logic [7:0] base,
                                         input logic [23:0] value, input logic [1:0] nbytes);
    logic [7:0] idx;
    idx = addr - base;
    byte_at = 8'h00;
    if (addr >= base && idx < {6'h00, nbytes})
      byte_at = value[idx[1:0]*8 +: 8];
  endfunction

  // ----------------------------------------------------------------
  // counter control
  // ----------------------------------------------------------------
  // a start edge only clears in full power; low-power states use the first measurement
  assign low_power = (power_state_i == 2'(low_power_state)) ||
                     (power_state_i == 2'(ultra_low_power_state));
  assign cur_clear = (current_conversion_start_i && !st.cur_start_prev &&
                      power_state_i == 2'(full_power_state)) ||
                     (first_meas_i && low_power); // RULE_13
  assign volt_clear = (voltage_conversion_start_i && !st.volt_start_prev &&
                       power_state_i == 2'(full_power_state)) ||
                      (first_meas_i && low_power); // RULE_16

  assign cur_if.clear = cur_clear;
  assign cur_if.done = cur_done_i;
  assign cur_if.limit = st.current_result_count_limit; // RULE_11
  assign volt_if.clear = volt_clear;
  assign volt_if.done = volt_done_i;
  assign volt_if.limit = st.voltage_result_count_limit; // RULE_15

  // current channel counter
  arc_rcount #(.W(CUR_CNT_W)) u_cur_count
  (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .port(cur_if.cnt)
  );

  // voltage channel counter
  arc_rcount #(.W(VOLT_CNT_W)) u_volt_count
  (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .port(volt_if.cnt)
  );

  // status events, one each for current, voltage and temperature
  assign status_set = {cur_if.strobe, volt_if.strobe, st.temp_ready}; // RULE_08

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.cur_start_prev = current_conversion_start_i;
    next_st.volt_start_prev = voltage_conversion_start_i;
    // results capture
    if (cur_done_i)
      next_st.current_result = current_result_i; // RULE_21
    if (volt_done_i)
      next_st.voltage_result = voltage_result_i; // RULE_01
    if (ref_done_i)
      next_st.reference_resistor_result = reference_resistor_result_i; // RULE_03
    if (temp_done_i)
      next_st.temperature_result = 16'(-temperature_result_i); // RULE_02
    next_st.temp_ready = temp_done_i; // RULE_09
    // software writes
    if (wr_i)
    begin
      case (addr_i)
        CUR_LIMIT_OFS: next_st.current_result_count_limit[7:0] = wdata_i; // RULE_11
        CUR_LIMIT_OFS + 8'h01: next_st.current_result_count_limit[15:8] = wdata_i; // RULE_11
        VOLT_LIMIT_OFS: next_st.voltage_result_count_limit = wdata_i[3:0]; // RULE_15 RULE_20
        GAIN_OFS: next_st.current_path_gain = wdata_i[GAIN_W-1:0]; // RULE_04 RULE_05 RULE_06 RULE_07
        STATUS_OFS: next_st.interrupt_status = st.interrupt_status & ~wdata_i[7:5];
        default: next_st.interrupt_status = st.interrupt_status;
      endcase
    end
    // events win over a clear in the same cycle
    next_st.interrupt_status = next_st.interrupt_status | status_set; // RULE_08
    // read data stand one cycle after the strobe only
    next_st.rdata = 8'h00;
    if (rd_i)
    begin
      next_st.rdata = byte_at(addr_i, CUR_RESULT_OFS, st.current_result, 2'd3) | // RULE_21
        byte_at(addr_i, VOLT_RESULT_OFS, st.voltage_result, 2'd3) | // RULE_01
        byte_at(addr_i, REF_RESULT_OFS, {8'h00, st.reference_resistor_result}, 2'd2) | // RULE_03
        byte_at(addr_i, TEMP_RESULT_OFS, {8'h00, st.temperature_result}, 2'd2) | // RULE_02
        byte_at(addr_i, CUR_COUNTER_OFS, {8'h00, cur_if.count}, 2'd2) | // RULE_12
        byte_at(addr_i, CUR_LIMIT_OFS, {8'h00, st.current_result_count_limit}, 2'd2);
      case (addr_i)
        VOLT_COUNTER_OFS: next_st.rdata = {4'h0, volt_if.count}; // RULE_18 RULE_20
        VOLT_LIMIT_OFS: next_st.rdata = {4'h0, st.voltage_result_count_limit}; // RULE_20
        GAIN_OFS: next_st.rdata = {3'h0, st.current_path_gain}; // RULE_07
        STATUS_OFS: next_st.rdata = {st.interrupt_status, 5'h00}; // RULE_08
        default: next_st.rdata = next_st.rdata;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      st <= '0;
      st.current_result <= RESULT24_RST;
      st.voltage_result <= RESULT24_RST;
      st.reference_resistor_result <= RESULT16_RST;
      st.temperature_result <= RESULT16_RST;
      st.current_result_count_limit <= CUR_LIMIT_RST;
      st.voltage_result_count_limit <= VOLT_LIMIT_RST;
      st.current_path_gain <= GAIN_RST;
    end
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o = st.rdata;
  assign cur_ready_o = cur_if.strobe; // RULE_10
  assign volt_ready_o = volt_if.strobe; // RULE_10
  assign temp_ready_o = st.temp_ready; // RULE_09
  assign input_front_stage_gain_o = st.current_path_gain[FRONT_LSB +: 2]; // RULE_04
  assign first_amp_gain_o = st.current_path_gain[FIRST_LSB +: 2]; // RULE_05
  assign second_amp_gain_o = st.current_path_gain[SECOND_BIT]; // RULE_06
  assign interrupt_status_o = st.interrupt_status;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_gain_write;
    wr_i && addr_i == GAIN_OFS;
  endsequence
  sequence s_cur_restart;
    cur_clear && !cur_done_i;
  endsequence

  a_volt_capture: assert property (volt_done_i |=> st.voltage_result == $past(voltage_result_i)) // RULE_01
    else $error("voltage result not captured");
  a_temp_invert: assert property (temp_done_i
      |=> st.temperature_result == 16'(-$past(temperature_result_i))) // RULE_02
    else $error("temperature result not sign-inverted");
  a_ref_capture: assert property (ref_done_i
      |=> st.reference_resistor_result == $past(reference_resistor_result_i)) // RULE_03
    else $error("reference resistor result not captured");
  a_gain_fields: assert property (s_gain_write |=> {second_amp_gain_o, first_amp_gain_o,
      input_front_stage_gain_o} == $past(wdata_i[4:0])) // RULE_04
    else $error("gain fields do not follow the write");
  a_gain_readback: assert property (s_gain_write ##1 (rd_i && addr_i == GAIN_OFS)
      |=> rdata_o[7:5] == 3'h0 && rdata_o[4:0] == $past(wdata_i[4:0], 2)) // RULE_07
    else $error("gain read back wrong or upper bits set");
  a_temp_ready: assert property (temp_done_i |=> temp_ready_o ##1 interrupt_status_o[ST_TEMP]) // RULE_09
    else $error("temperature ready not raised");
  a_status_sticky: assert property (cur_ready_o |=> interrupt_status_o[ST_CUR]) // RULE_08
    else $error("current status bit not set");
  a_cur_clear: assert property (s_cur_restart |=> cur_if.count == 16'h0000) // RULE_13
    else $error("current counter not cleared");
  a_volt_clear: assert property (volt_clear && !volt_done_i |=> volt_if.count == 4'h0) // RULE_16
    else $error("voltage counter not cleared");
  a_read_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside the answer cycle");
endmodule // arc_regs
`default_nettype wire
